// ===== hicr_pkg.sv
package hicr_pkg;
    // Register addresses
    localparam logic [7:0] ADDR_PRODUCT_ID_LOW  = 8'h02;
    localparam logic [7:0] ADDR_PRODUCT_ID_HIGH = 8'h03;
    localparam logic [7:0] ADDR_RELEASE_LOW     = 8'h04;
    localparam logic [7:0] ADDR_RELEASE_HIGH    = 8'h05;
    localparam logic [7:0] ADDR_SETUP_FIRST     = 8'h06;
    localparam logic [7:0] ADDR_SETUP_SECOND    = 8'h07;
    // Field positions
    localparam int POWER_SOURCE_BIT    = 7;
    localparam int RESERVED_BIT        = 6;
    localparam int FULL_SPEED_ONLY_BIT = 5;
    localparam int DYNAMIC_POWER_BIT   = 7;
    // Reset values
    localparam logic [7:0] RESET_BYTE  = 8'h00;
    // Mask of storable bits in the first setup byte
    localparam logic [7:0] SETUP_FIRST_MASK = 8'hbf;
endpackage

// ===== hicr_regs.sv
`timescale 1ns/1ps
// Contract
// - Hold product identifier upper byte at 0x03, paired with lower byte at 0x02.
// - Release number is BCD, reported unchanged as 16-bit release value.
// - Release number low byte at 0x04, high byte at 0x05.
// - Accept register writes from either the SMBus port or EEPROM loader.
// - First setup bit 7 selects bus-powered (0) or self-powered (1).
// - With dynamic switching on, power mode follows the local supply pin.
// - First setup bit 5 forces full-speed-only attachment when set.
// - Second setup bit 7 enables dynamic switching; supply change triggers re-attach.
module hicr_regs (
    input  wire logic       clk_i,                // 100 MHz clock
    input  wire logic       rst_i,                // Sync reset, active high
    input  wire logic       smb_wr_i,             // SMBus write strobe
    input  wire logic [7:0] smb_addr_i,           // SMBus register address
    input  wire logic [7:0] smb_wdata_i,          // SMBus write data
    input  wire logic [7:0] smb_raddr_i,          // SMBus read address
    output logic      [7:0] smb_rdata_o,          // SMBus read data
    input  wire logic       eep_wr_i,             // EEPROM loader write strobe
    input  wire logic [7:0] eep_addr_i,           // EEPROM loader address
    input  wire logic [7:0] eep_wdata_i,          // EEPROM loader data
    input  wire logic       local_supply_present_i, // Local power pin, async
    output logic [15:0]     product_id_o,         // Product identifier
    output logic [15:0]     release_bcd_o,        // Device release, BCD
    output logic            self_powered_o,       // Effective power mode
    output logic            full_speed_only_o,    // Hi-speed disabled
    output logic            reattach_o            // One-cycle re-attach request
);
    logic [7:0] pid_low_reg, pid_low_next;
    logic [7:0] pid_high_reg, pid_high_next;
    logic [7:0] rel_low_reg, rel_low_next;
    logic [7:0] rel_high_reg, rel_high_next;
    logic [7:0] setup1_reg, setup1_next;
    logic [7:0] setup2_reg, setup2_next;
    logic       sync1_reg, sync1_next;
    logic       sync2_reg, sync2_next;
    logic       supply_reg, supply_next;
    logic [7:0] rdata_reg, rdata_next;
    logic       self_reg, self_next;
    logic       reattach_reg, reattach_next;
    logic       wr;
    logic [7:0] waddr;
    logic [7:0] wdata;

    // SMBus wins if both paths strobe in one cycle
    always_comb
    begin
        wr    = smb_wr_i | eep_wr_i;
        waddr = smb_wr_i ? smb_addr_i : eep_addr_i;
        wdata = smb_wr_i ? smb_wdata_i : eep_wdata_i;
        pid_low_next  = pid_low_reg;
        pid_high_next = pid_high_reg;
        rel_low_next  = rel_low_reg;
        rel_high_next = rel_high_reg;
        setup1_next   = setup1_reg;
        setup2_next   = setup2_reg;
        if (wr)
        begin
            unique case (waddr)
                hicr_pkg::ADDR_PRODUCT_ID_LOW:  pid_low_next  = wdata;
                hicr_pkg::ADDR_PRODUCT_ID_HIGH: pid_high_next = wdata;
                hicr_pkg::ADDR_RELEASE_LOW:     rel_low_next  = wdata;
                hicr_pkg::ADDR_RELEASE_HIGH:    rel_high_next = wdata;
                hicr_pkg::ADDR_SETUP_FIRST:
                    setup1_next = wdata & hicr_pkg::SETUP_FIRST_MASK;
                hicr_pkg::ADDR_SETUP_SECOND:    setup2_next   = wdata;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pid_low_reg  <= hicr_pkg::RESET_BYTE;
            pid_high_reg <= hicr_pkg::RESET_BYTE;
            rel_low_reg  <= hicr_pkg::RESET_BYTE;
            rel_high_reg <= hicr_pkg::RESET_BYTE;
            setup1_reg   <= hicr_pkg::RESET_BYTE;
            setup2_reg   <= hicr_pkg::RESET_BYTE;
            rdata_reg    <= hicr_pkg::RESET_BYTE;
        end
        else
        begin
            pid_low_reg  <= pid_low_next;
            pid_high_reg <= pid_high_next;
            rel_low_reg  <= rel_low_next;
            rel_high_reg <= rel_high_next;
            setup1_reg   <= setup1_next;
            setup2_reg   <= setup2_next;
            rdata_reg    <= rdata_next;
        end
    end

    // Read mux; unmapped addresses read zero
    // Read byte is registered: one cycle of latency buys a clean output
    always_comb
    begin
        unique case (smb_raddr_i)
            hicr_pkg::ADDR_PRODUCT_ID_LOW:  rdata_next = pid_low_reg;
            hicr_pkg::ADDR_PRODUCT_ID_HIGH: rdata_next = pid_high_reg;
            hicr_pkg::ADDR_RELEASE_LOW:     rdata_next = rel_low_reg;
            hicr_pkg::ADDR_RELEASE_HIGH:    rdata_next = rel_high_reg;
            hicr_pkg::ADDR_SETUP_FIRST:     rdata_next = setup1_reg;
            hicr_pkg::ADDR_SETUP_SECOND:    rdata_next = setup2_reg;
            default:                        rdata_next = 8'h00;
        endcase
    end

    // Pin synchroniser, then power mode decision
    always_comb
    begin
        // Only the second and third stages feed logic; the first may still be settling
        sync1_next  = local_supply_present_i;
        sync2_next  = sync1_reg;
        supply_next = sync2_reg;
        if (setup2_reg[hicr_pkg::DYNAMIC_POWER_BIT])
            self_next = supply_reg;
        else
            self_next = setup1_reg[hicr_pkg::POWER_SOURCE_BIT];
        // Any supply change while dynamic switching is on forces re-attach
        reattach_next = setup2_reg[hicr_pkg::DYNAMIC_POWER_BIT]
                        & (sync2_reg ^ supply_reg);
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sync1_reg    <= 1'b0;
            sync2_reg    <= 1'b0;
            supply_reg   <= 1'b0;
            self_reg     <= 1'b0;
            reattach_reg <= 1'b0;
        end
        else
        begin
            sync1_reg    <= sync1_next;
            sync2_reg    <= sync2_next;
            supply_reg   <= supply_next;
            self_reg     <= self_next;
            reattach_reg <= reattach_next;
        end
    end

    assign smb_rdata_o       = rdata_reg;
    assign product_id_o      = {pid_high_reg, pid_low_reg};
    assign release_bcd_o     = {rel_high_reg, rel_low_reg};
    assign self_powered_o    = self_reg;
    assign full_speed_only_o = setup1_reg[hicr_pkg::FULL_SPEED_ONLY_BIT];
    assign reattach_o        = reattach_reg;

    a_product_high_write: assert property (@(posedge clk_i) disable iff (rst_i)
        smb_wr_i && smb_addr_i == hicr_pkg::ADDR_PRODUCT_ID_HIGH
        |=> product_id_o[15:8] == $past(smb_wdata_i))
        else $error("product id high byte not stored");
    a_release_value: assert property (@(posedge clk_i) disable iff (rst_i)
        wr && waddr == hicr_pkg::ADDR_RELEASE_HIGH
        |=> release_bcd_o == {$past(wdata), $past(release_bcd_o[7:0])})
        else $error("release value altered");
    a_release_low_write: assert property (@(posedge clk_i) disable iff (rst_i)
        smb_wr_i && smb_addr_i == hicr_pkg::ADDR_RELEASE_LOW
        |=> release_bcd_o[7:0] == $past(smb_wdata_i))
        else $error("release low byte not stored");
    a_eeprom_load: assert property (@(posedge clk_i) disable iff (rst_i)
        eep_wr_i && !smb_wr_i && eep_addr_i == hicr_pkg::ADDR_RELEASE_HIGH
        |=> release_bcd_o[15:8] == $past(eep_wdata_i))
        else $error("eeprom load lost");
    a_product_low_pair: assert property (@(posedge clk_i) disable iff (rst_i)
        wr && waddr == hicr_pkg::ADDR_PRODUCT_ID_LOW
        |=> product_id_o == {$past(product_id_o[15:8]), $past(wdata)})
        else $error("product id pairing broken");
    a_smbus_priority: assert property (@(posedge clk_i) disable iff (rst_i)
        smb_wr_i && eep_wr_i && eep_addr_i == hicr_pkg::ADDR_RELEASE_LOW
        && smb_addr_i == hicr_pkg::ADDR_RELEASE_LOW
        |=> release_bcd_o[7:0] == $past(smb_wdata_i))
        else $error("smbus write lost to loader");

    // Power decision steps: setup steady, then a synchronised supply edge
    sequence s_static_steady;
        !setup2_reg[hicr_pkg::DYNAMIC_POWER_BIT] && $stable(setup2_reg);
    endsequence
    sequence s_dynamic_steady;
        setup2_reg[hicr_pkg::DYNAMIC_POWER_BIT] && $stable(setup2_reg);
    endsequence
    sequence s_supply_edge;
        setup2_reg[hicr_pkg::DYNAMIC_POWER_BIT] && $stable(setup2_reg)
            && (sync2_reg != supply_reg);
    endsequence
    sequence s_first_setup_write;
        wr && waddr == hicr_pkg::ADDR_SETUP_FIRST;
    endsequence

    a_static_power: assert property (@(posedge clk_i) disable iff (rst_i)
        s_static_steady |=> self_powered_o == $past(setup1_reg[hicr_pkg::POWER_SOURCE_BIT]))
        else $error("static power mode wrong");
    a_dynamic_power: assert property (@(posedge clk_i) disable iff (rst_i)
        s_dynamic_steady |=> self_powered_o == $past(supply_reg))
        else $error("dynamic power mode wrong");
    a_speed_select: assert property (@(posedge clk_i) disable iff (rst_i)
        s_first_setup_write
        |=> full_speed_only_o == $past(wdata[hicr_pkg::FULL_SPEED_ONLY_BIT]))
        else $error("speed select mismatch");
    a_speed_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        !wr || waddr != hicr_pkg::ADDR_SETUP_FIRST |=> $stable(full_speed_only_o))
        else $error("speed select changed unwritten");
    a_reattach_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
        s_supply_edge |=> reattach_o)
        else $error("reattach not raised");
    a_reattach_idle: assert property (@(posedge clk_i) disable iff (rst_i)
        !setup2_reg[hicr_pkg::DYNAMIC_POWER_BIT] |=> !reattach_o)
        else $error("reattach while switching off");

    a_reserved_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        setup1_reg[hicr_pkg::RESERVED_BIT] == 1'b0)
        else $error("reserved bit set");
    a_reserved_read: assert property (@(posedge clk_i) disable iff (rst_i)
        smb_raddr_i == hicr_pkg::ADDR_SETUP_FIRST |=> smb_rdata_o[hicr_pkg::RESERVED_BIT] == 1'b0)
        else $error("reserved bit read back set");
    a_read_product: assert property (@(posedge clk_i) disable iff (rst_i)
        smb_raddr_i == hicr_pkg::ADDR_PRODUCT_ID_HIGH |=> smb_rdata_o == $past(product_id_o[15:8]))
        else $error("product id high read wrong");
    a_read_release: assert property (@(posedge clk_i) disable iff (rst_i)
        smb_raddr_i == hicr_pkg::ADDR_RELEASE_HIGH |=> smb_rdata_o == $past(release_bcd_o[15:8]))
        else $error("release high read wrong");
endmodule

// ===== hicr_host.sv
`timescale 1ns/1ps
module hicr_host (
    input  wire logic       clk_i,       // Bench clock
    output logic            smb_wr_o,    // SMBus write strobe
    output logic      [7:0] smb_addr_o,  // SMBus address
    output logic      [7:0] smb_wdata_o, // SMBus data
    output logic            eep_wr_o,    // Loader write strobe
    output logic      [7:0] eep_addr_o,  // Loader address
    output logic      [7:0] eep_wdata_o  // Loader data
);
    initial
    begin
        {smb_wr_o, smb_addr_o, smb_wdata_o} = 17'h0;
        {eep_wr_o, eep_addr_o, eep_wdata_o} = 17'h0;
    end
    // Either path writes the same bytes; released lines show inverted junk
    task automatic put(input logic eep, input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_i);
        if (eep)
            {eep_wr_o, eep_addr_o, eep_wdata_o} = {1'b1, a, d};
        else
            {smb_wr_o, smb_addr_o, smb_wdata_o} = {1'b1, a, d};
        @(negedge clk_i);
        {smb_wr_o, eep_wr_o} = 2'h0;
        {smb_addr_o, smb_wdata_o, eep_addr_o, eep_wdata_o} = {~a, ~d, ~a, ~d};
    endtask
    // Both paths strobe in one cycle to exercise write priority
    task automatic put_both(input logic [7:0] a, input logic [7:0] ds, input logic [7:0] de);
        @(negedge clk_i);
        {smb_wr_o, smb_addr_o, smb_wdata_o} = {1'b1, a, ds};
        {eep_wr_o, eep_addr_o, eep_wdata_o} = {1'b1, a, de};
        @(negedge clk_i);
        {smb_wr_o, eep_wr_o} = 2'h0;
        {smb_addr_o, smb_wdata_o, eep_addr_o, eep_wdata_o} = {~a, ~ds, ~a, ~de};
    endtask
endmodule

// ===== hicr_regs_test.sv
`timescale 1ns/1ps
module hicr_regs_test;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic [7:0]  raddr = 8'h00;
    logic        supply = 1'b0;
    logic        smb_wr, eep_wr, selfp, fso, reat;
    logic [7:0]  smb_addr, smb_wdata, eep_addr, eep_wdata, rdata;
    logic [15:0] pid, rel;
    int          miscompares = 0;
    int          n_tests = 0;
    int          cycles = 0;
    hicr_host i_hicr_host (.clk_i(clk_i), .smb_wr_o(smb_wr), .smb_addr_o(smb_addr),
        .smb_wdata_o(smb_wdata), .eep_wr_o(eep_wr), .eep_addr_o(eep_addr),
        .eep_wdata_o(eep_wdata));
    hicr_regs i_hicr_regs (.clk_i(clk_i), .rst_i(rst_i), .smb_wr_i(smb_wr),
        .smb_addr_i(smb_addr), .smb_wdata_i(smb_wdata), .smb_raddr_i(raddr),
        .smb_rdata_o(rdata), .eep_wr_i(eep_wr), .eep_addr_i(eep_addr),
        .eep_wdata_i(eep_wdata), .local_supply_present_i(supply), .product_id_o(pid),
        .release_bcd_o(rel), .self_powered_o(selfp), .full_speed_only_o(fso),
        .reattach_o(reat));
    always #5 clk_i = ~clk_i;
    always @(posedge clk_i)
    begin
        cycles++;
        // Whole run needs well under 200 cycles
        if (cycles == 2000)
        begin
            miscompares++;
            final_report();
        end
    end
    task automatic final_report();
        if (miscompares == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        raddr = a;
        @(negedge clk_i);
        chk({8'h00, rdata}, {8'h00, exp});
    endtask
    task automatic t_product();
        i_hicr_host.put(1'b0, 8'h02, 8'h34);
        i_hicr_host.put(1'b0, 8'h03, 8'h12);
        chk(pid, 16'h1234);
        rd(8'h03, 8'h12);
        i_hicr_host.put(1'b0, 8'h20, 8'haa);
        chk(pid, 16'h1234);
        rd(8'h20, 8'h00);
    endtask
    task automatic t_release();
        i_hicr_host.put(1'b1, 8'h04, 8'h99);
        i_hicr_host.put(1'b1, 8'h05, 8'h20);
        chk(rel, 16'h2099);
        rd(8'h04, 8'h99);
        rd(8'h05, 8'h20);
    endtask
    task automatic t_setup();
        i_hicr_host.put(1'b0, 8'h06, 8'hff);
        rd(8'h06, 8'hbf);
        chk({15'h0, fso}, 16'h1);
        @(negedge clk_i);
        chk({15'h0, selfp}, 16'h1);
        i_hicr_host.put(1'b1, 8'h06, 8'h40);
        rd(8'h06, 8'h00);
        chk({15'h0, fso}, 16'h0);
        @(negedge clk_i);
        chk({15'h0, selfp}, 16'h0);
    endtask
    task automatic t_dynamic();
        int hits;
        hits = 0;
        i_hicr_host.put(1'b0, 8'h06, 8'h80);
        i_hicr_host.put(1'b0, 8'h07, 8'h80);
        repeat (2) @(negedge clk_i);
        chk({15'h0, selfp}, 16'h0);
        supply = 1'b1;
        repeat (10)
        begin
            @(negedge clk_i);
            hits += (reat === 1'b1);
        end
        chk(16'(hits), 16'h1);
        chk({15'h0, selfp}, 16'h1);
        hits = 0;
        supply = 1'b0;
        repeat (10)
        begin
            @(negedge clk_i);
            hits += (reat === 1'b1);
        end
        chk(16'(hits), 16'h1);
        chk({15'h0, selfp}, 16'h0);
        // Switching off: pin edges ignored, static select rules again
        i_hicr_host.put(1'b0, 8'h07, 8'h3c);
        rd(8'h07, 8'h3c);
        hits = 0;
        supply = 1'b1;
        repeat (10)
        begin
            @(negedge clk_i);
            hits += (reat === 1'b1);
        end
        chk(16'(hits), 16'h0);
        chk({15'h0, selfp}, 16'h1);
    endtask
    task automatic t_priority();
        i_hicr_host.put_both(8'h04, 8'h11, 8'h22);
        chk(rel, 16'h2011);
        rd(8'h04, 8'h11);
    endtask
    task automatic t_reset();
        rst_i = 1'b1;
        repeat (2) @(negedge clk_i);
        chk(pid, 16'h0000);
        chk(rel, 16'h0000);
        chk({6'h0, rdata, selfp, fso}, 16'h0000);
        rst_i = 1'b0;
        i_hicr_host.put(1'b0, 8'h03, 8'h56);
        chk(pid, 16'h5600);
    endtask
    initial
    begin
        repeat (2) @(negedge clk_i);
        chk(pid, 16'h0000);
        chk(rel, 16'h0000);
        chk({13'h0, selfp, fso, reat}, 16'h0000);
        rst_i = 1'b0;
        t_product();
        t_release();
        t_priority();
        t_setup();
        t_dynamic();
        t_reset();
        final_report();
    end
endmodule
